// ==== rtl/lsd_pkg.sv ====
/*
 * Shared constants and carrier types for the linear sensor scan model.
 * Assumes a single 25 MHz clock domain; pin inputs are synchronised in the sensor.
 */
package lsd_pkg;

    // Array size and pixel index width
    localparam int LSD_NPIX = 128;
    localparam int LSD_IDX_W = 7;
    localparam logic [6:0] LSD_LAST_IDX = 7'h7f;

    // Charge model widths
    localparam int LSD_INTEG_W = 24;
    localparam int LSD_VAL_W = 16;
    localparam logic [15:0] LSD_VAL_MAX = 16'hffff;

    // Clock rate and the least saturation gate pulse
    localparam int LSD_CLK_NS = 40;
    localparam int LSD_SAT_MIN_NS = 5000;
    localparam int LSD_SAT_MIN_CYC = (LSD_SAT_MIN_NS + LSD_CLK_NS - 1) / LSD_CLK_NS;
    localparam logic [7:0] LSD_SAT_MIN_CYC8 = 8'(LSD_SAT_MIN_CYC);

    // Output buffer depth
    localparam int LSD_FIFO_DEPTH = 16;

    // Reset values
    localparam logic [23:0] LSD_INTEG_RST = 24'h000000;

    // Drive pins from the timing generator
    typedef struct packed {
        logic phase1;
        logic phase2;
        logic scan_start_pulse;
        logic video_reset;
        logic sat_gate;
    } lsd_pins_t;

    // One pixel sample on the video stream
    typedef struct packed {
        logic last;
        logic [LSD_IDX_W-1:0] index;
        logic [LSD_VAL_W-1:0] value;
    } lsd_pixel_t;

endpackage

// ==== rtl/lsd_fifo.sv ====
/*
 * Small synchronous FIFO with a registered output stage.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module lsd_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Fill side
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);

    // Whole FIFO state
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [W-1:0] od;
    } lsd_fifo_st_t;

    lsd_fifo_st_t q, d;
    logic push; // Accepted write
    logic load; // Move head into output stage

    // Full means the storage holds DEPTH words; the output stage is extra
    assign o_ready = (q.cnt != (AW+1)'(DEPTH));
    assign o_valid = q.ov;
    assign o_data = q.od;

    // Next state
    always_comb begin
        d = q;
        push = i_valid && o_ready;
        load = (q.cnt != '0) && (!q.ov || i_ready);
        if (push) begin
            d.mem[q.wp] = i_data;
            d.wp = q.wp + 1'b1;
        end
        if (load) begin
            // Head comes from storage, so a push in the same cycle waits a cycle
            d.od = q.mem[q.rp];
            d.rp = q.rp + 1'b1;
            d.ov = 1'b1;
        end else if (q.ov && i_ready) begin
            d.ov = 1'b0;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
    end

    // State register
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule // lsd_fifo

`default_nettype wire

// ==== rtl/lsd_sensor.sv ====
/*
 * Digital model of a self-scanning linear photodiode array readout.
 * Assumes drive pins arrive asynchronously and light intensity on i_mclk.
 */
// Behaviour
// - Scan-done low on phase2 after last pixel
// - Gate high holds all photodiodes reset
// - Gate low lets photodiodes integrate freely
// - Reading a pixel clears its charge
// - One pixel per phase2 rising edge
`timescale 1ns/1ps
`default_nettype none

module lsd_sensor (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // Drive pins, asynchronous
    input wire lsd_pkg::lsd_pins_t i_pins,
    // Light intensity per clock, same domain
    input wire logic [7:0] i_light,
    // Pixel stream out
    input wire logic i_pix_ready,
    output logic o_pix_valid,
    output lsd_pkg::lsd_pixel_t o_pix,
    // Status
    output logic o_scan_done_n,
    output logic o_fill_ready,
    output logic o_overrun,
    output logic o_order_err,
    output logic o_gate_short
);
    import lsd_pkg::*;

    // Whole module state
    typedef struct packed {
        lsd_pins_t s1; // First sync stage, read only by s2
        lsd_pins_t s2; // Synchronised pins
        lsd_pins_t prev; // Previous synchronised pins, for edges
        logic [LSD_INTEG_W-1:0] integ; // Running light integral
        logic [LSD_NPIX-1:0][LSD_INTEG_W-1:0] snap; // Integral at last reset
        logic pending; // Start seen, first pixel on next phase2 rise
        logic scanning; // Shift register running
        logic [LSD_IDX_W-1:0] idx; // Next pixel address
        logic eos_next; // Last pixel addressed, done on next rise
        logic done_n; // Scan-done pin
        logic wvalid; // Pixel write toward FIFO
        lsd_pixel_t wdata;
        logic fill_rdy; // Registered copy of FIFO ready
        logic ovr;
        logic order_err;
        logic gate_short;
        logic [7:0] gate_cnt;
        logic step_armed; // Last pixel written was not the final one
        logic [LSD_IDX_W-1:0] step_next; // Index that must follow it
    } lsd_st_t;

    lsd_st_t q, d;
    logic fifo_ready; // FIFO accepts a word this cycle
    logic p2_rise;
    logic p2_fall;
    logic active; // A pixel is addressed on this rise
    logic [LSD_IDX_W-1:0] cur; // Address read on this rise
    logic [LSD_INTEG_W-1:0] diff; // Charge collected since last reset

    assign o_scan_done_n = q.done_n;
    assign o_fill_ready = q.fill_rdy;
    assign o_overrun = q.ovr;
    assign o_order_err = q.order_err;
    assign o_gate_short = q.gate_short;

    // Edges of the synchronised phase2
    assign p2_rise = q.s2.phase2 && !q.prev.phase2;
    assign p2_fall = !q.s2.phase2 && q.prev.phase2;

    // Next state
    always_comb begin
        d = q;
        d.s1 = i_pins;
        d.s2 = q.s1;
        d.prev = q.s2;
        // Integral wraps; differences stay right while under 2^24 counts
        d.integ = q.integ + LSD_INTEG_W'(i_light);
        d.wvalid = 1'b0;
        d.fill_rdy = fifo_ready;
        active = q.pending || q.scanning;
        cur = q.pending ? '0 : q.idx;
        diff = q.integ - q.snap[cur];

        // Gate high pins every photodiode to the drain potential
        if (q.s2.sat_gate) begin
            for (int i = 0; i < LSD_NPIX; i++) begin
                d.snap[i] = q.integ;
            end
        end
        // With the gate low the snapshots stay, so charge keeps growing

        // Start is taken at the phase2 fall inside its high time
        if (p2_fall) begin
            d.done_n = 1'b1;
            if (q.s2.scan_start_pulse) begin
                d.pending = 1'b1;
            end
        end

        if (p2_rise) begin
            // Done marker after the last pixel, low for one phase2 high time (6 clocks)
            if (q.eos_next) begin
                d.done_n = 1'b0;
                d.eos_next = 1'b0;
            end
            if (active) begin
                d.pending = 1'b0;
                d.wvalid = 1'b1;
                d.wdata.index = cur;
                d.wdata.last = (cur == LSD_LAST_IDX);
                if (q.s2.sat_gate) begin
                    d.wdata.value = '0;
                end else if (|diff[LSD_INTEG_W-1:LSD_VAL_W]) begin
                    d.wdata.value = LSD_VAL_MAX; // Saturated photodiode
                end else begin
                    d.wdata.value = diff[LSD_VAL_W-1:0];
                end
                d.snap[cur] = q.integ;
                if (cur == LSD_LAST_IDX) begin
                    d.scanning = 1'b0;
                    d.eos_next = 1'b1;
                end else begin
                    d.scanning = 1'b1;
                    d.idx = cur + 1'b1;
                end
            end
        end

        // A pixel is lost when the buffer is full; sticky until reset
        if (q.wvalid && !fifo_ready) begin
            d.ovr = 1'b1;
        end

        // Remember where the scan must go next, kept apart from idx so the
        // address check does not just compare the counter with itself
        if (q.wvalid) begin
            d.step_armed = !q.wdata.last;
            d.step_next = q.wdata.index + 1'b1;
        end

        // Drive-order faults: phases overlap, reset edge in wrong phase
        if (q.s2.phase1 && q.s2.phase2) begin
            d.order_err = 1'b1;
        end
        if (q.s2.video_reset && !q.prev.video_reset && !q.s2.phase2) begin
            d.order_err = 1'b1;
        end
        if (!q.s2.video_reset && q.prev.video_reset && q.s2.phase2) begin
            d.order_err = 1'b1;
        end

        // Gate pulse width check; counter saturates at the minimum
        if (q.s2.sat_gate) begin
            if (q.gate_cnt != LSD_SAT_MIN_CYC8) begin
                d.gate_cnt = q.gate_cnt + 8'h01;
            end
        end else begin
            d.gate_cnt = 8'h00;
            if (q.prev.sat_gate && (q.gate_cnt != LSD_SAT_MIN_CYC8)) begin
                d.gate_short = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            q <= '0;
            q.integ <= LSD_INTEG_RST;
            q.done_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Output buffer; its registered head drives the pixel stream
    lsd_fifo #(
        .W($bits(lsd_pixel_t)),
        .DEPTH(LSD_FIFO_DEPTH)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_valid(q.wvalid),
        .i_data(q.wdata),
        .o_ready(fifo_ready),
        .o_valid(o_pix_valid),
        .o_data(o_pix),
        .i_ready(i_pix_ready)
    );

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    sequence last_read_s;
        q.wvalid && q.wdata.last;
    endsequence

    // A later write in the same scan; a restart at index 0 is allowed
    sequence next_read_s;
        q.wvalid && q.step_armed && (q.wdata.index != '0);
    endsequence

    // Done falls only with phase2 high and one rise after a last pixel
    done_aligned_a: assert property ($fell(o_scan_done_n) |-> q.prev.phase2)
        else $error("scan done fell outside phase2 high");
    done_after_last_a: assert property ($fell(o_scan_done_n) |-> $past(q.eos_next))
        else $error("scan done without a finished scan");
    last_sets_eos_a: assert property (last_read_s |-> q.eos_next && !q.scanning)
        else $error("last pixel did not arm scan done");
    sat_zero_a: assert property (q.wvalid && $past(q.s2.sat_gate) |-> q.wdata.value == '0)
        else $error("pixel read nonzero under saturation gate");
    sat_hold_a: assert property ($past(q.s2.sat_gate) |-> q.snap[0] == $past(q.integ))
        else $error("photodiode not held reset under gate");
    integ_keep_a: assert property (!$past(q.s2.sat_gate) && !$past(p2_rise)
        |-> q.snap == $past(q.snap))
        else $error("photodiode charge changed while integrating");
    read_clear_a: assert property (q.wvalid |-> q.snap[q.wdata.index] == $past(q.integ))
        else $error("read pixel not cleared");
    pixel_rise_a: assert property (q.wvalid |-> $past(p2_rise))
        else $error("pixel written away from phase2 rise");
    pixel_step_a: assert property (next_read_s |-> q.wdata.index == q.step_next)
        else $error("pixel address did not advance");

endmodule // lsd_sensor

`default_nettype wire

// ==== tb/lsd_drv_model.sv ====
/*
 * Timing generator model: two-phase scan clock, start, video reset, gate.
 * Assumes i_run is held high for whole scans of 131 pixel periods.
 */
`timescale 1ns/1ps
`default_nettype none

module lsd_drv_model (
    // Clock and control from the bench
    input wire logic i_mclk,
    input wire logic i_run,
    input wire logic i_gate,
    // Pins to the sensor
    output lsd_pkg::lsd_pins_t o_pins
);
    import lsd_pkg::*;

    logic [3:0] c_q = 4'h0; // Clock within a 16 clock pixel period
    logic [7:0] p_q = 8'h00; // Period within scan: start, 128 pixels, done, spare

    // Counters stop only at a scan boundary, so clocks stand still when idle
    always @(posedge i_mclk) begin
        if (i_run || c_q != 4'h0 || p_q != 8'h00) begin
            c_q <= #1 c_q + 4'h1;
            if (c_q == 4'hf)
                p_q <= #1 (p_q == 8'h82) ? 8'h00 : p_q + 8'h01;
        end
    end

    // Phases never overlap, each high 6 clocks (240 ns)
    always_comb begin
        o_pins.phase1 = (c_q >= 4'h1) && (c_q <= 4'h6);
        o_pins.phase2 = (c_q >= 4'h9) && (c_q <= 4'he);
        // Rises with phase2 high, falls with phase2 low, once a period
        o_pins.video_reset = (c_q >= 4'ha);
        // Eight clocks high, six overlap phase2, one phase2 fall inside
        o_pins.scan_start_pulse = (p_q == 8'h00) && (c_q >= 4'h8);
        o_pins.sat_gate = i_gate;
    end
endmodule // lsd_drv_model
`default_nettype wire

// ==== tb/testbench.sv ====
/*
 * Self-checking bench for the sensor readout model.
 * Assumes the timing generator model drives every pin.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import lsd_pkg::*;

    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic run = 1'b0;
    logic gate = 1'b0;
    logic rdy = 1'b1;
    lsd_pins_t pins;
    logic pv, dn, fr, ovr, oerr, gs;
    lsd_pixel_t pix;
    lsd_pixel_t q[$]; // Words taken from the stream
    int dlow = 0; // Cycles with scan done low
    int fail_count = 0;
    int total_checks = 0;

    always #20 i_mclk = ~i_mclk;

    lsd_drv_model lsd_drv_model_inst (.i_mclk(i_mclk), .i_run(run), .i_gate(gate),
        .o_pins(pins));
    lsd_sensor lsd_sensor_inst (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_pins(pins),
        .i_light(8'h01), .i_pix_ready(rdy), .o_pix_valid(pv), .o_pix(pix),
        .o_scan_done_n(dn), .o_fill_ready(fr), .o_overrun(ovr), .o_order_err(oerr),
        .o_gate_short(gs));

    // Collect accepted words and time the done marker
    always @(posedge i_mclk) begin
        if (pv === 1'b1 && rdy === 1'b1)
            q.push_back(pix);
        if (dn === 1'b0)
            dlow++;
    end

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Run n back-to-back scans, then let the pipeline drain
    task automatic scans(input int n);
        q.delete();
        @(posedge i_mclk) #1 run = 1'b1;
        repeat (2096 * n - 8) @(posedge i_mclk);
        #1 run = 1'b0;
        repeat (80) @(posedge i_mclk);
    endtask

    // Order, last flag, done pulse, and clear-at-read interval
    task automatic t_normal();
        dlow = 0;
        scans(2);
        check("count", 24'(q.size()), 24'd256);
        for (int i = 0; i < q.size(); i++) begin
            check("index", 24'(q[i].index), 24'(i % 128));
            check("last", 24'(q[i].last), 24'(i % 128 == 127));
            if (i > 128)
                check("same", 24'(q[i].value), 24'(q[128].value));
        end
        check("interval", 24'(q[128].value >= 16'd2094 && q[128].value <= 16'd2098), 24'h1);
        check("done_low", 24'(dlow), 24'd12);
    endtask

    // Gate high zeroes charge; after release charge grows 16 per pixel
    task automatic t_gate();
        #1 gate = 1'b1;
        repeat (10) @(posedge i_mclk);
        scans(1);
        check("count1", 24'(q.size()), 24'd128);
        for (int i = 0; i < q.size(); i++)
            check("gated", 24'(q[i].value), 24'h0);
        #1 gate = 1'b0;
        scans(1);
        check("count2", 24'(q.size()), 24'd128);
        for (int i = 1; i < q.size(); i++)
            check("step", 24'(q[i].value - q[i-1].value), 24'h10);
        check("long_gate", 24'(gs), 24'h0);
    endtask

    // Stalled drain: buffer fills, excess is dropped, then drains in order
    task automatic t_stall();
        #1 rdy = 1'b0;
        scans(1);
        check("overrun", 24'(ovr), 24'h1);
        check("full", 24'(fr), 24'h0);
        #1 rdy = 1'b1;
        repeat (40) @(posedge i_mclk);
        check("kept", 24'(q.size()), 24'd17);
        for (int i = 0; i < q.size(); i++)
            check("kidx", 24'(q[i].index), 24'(i));
    endtask

    // Gate pulse under the minimum width is flagged
    task automatic t_short();
        @(posedge i_mclk) #1 gate = 1'b1;
        repeat (50) @(posedge i_mclk);
        #1 gate = 1'b0;
        repeat (10) @(posedge i_mclk);
        check("short_gate", 24'(gs), 24'h1);
        check("order", 24'(oerr), 24'h0);
    endtask

    initial begin
        repeat (16) @(posedge i_mclk);
        #1 i_resetn = 1'b1;
        repeat (4) @(posedge i_mclk);
        t_normal();
        t_gate();
        t_stall();
        t_short();
        end_sim();
    end

    // Watchdog: all scenarios need about 11000 cycles
    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        end_sim();
    end
endmodule // testbench
`default_nettype wire
